/* sldc_pkg.sv */
package sldc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_LINK_CTRL = 8'h04;
    localparam logic [7:0] ADDR_PLL_CTRL = 8'h05;
    localparam logic [7:0] ADDR_LINE_FAULT = 8'h08;
    // Field positions
    localparam int PRBS_BIT = 5;
    localparam int SERIAL_LINK_ENABLE_BIT = 7;
    localparam int CLINK_BIT = 6;
    localparam int FWD_CC_BIT = 0;
    localparam int REV_CC_BIT = 1;
    localparam int JPLL_DIS_BIT = 6;
    // Reset values
    localparam logic [7:0] LINK_CTRL_RST = 8'h03;
    localparam logic [7:0] PLL_CTRL_RST = 8'h00;
    // Wire fault codes
    localparam logic [1:0] FAULT_SHORT_BATT = 2'h0;
    localparam logic [1:0] FAULT_SHORT_GND = 2'h1;
    localparam logic [1:0] FAULT_NORMAL = 2'h2;
    localparam logic [1:0] FAULT_OPEN = 2'h3;
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int REV_HOLD_US = 350;
    localparam int REV_HOLD_CYC = (REV_HOLD_US * (CLK_HZ / 1_000_000));
    localparam int BIT_RATE_MAX_BPS = 1_000_000;
    localparam int MIN_BIT_CYC = (CLK_HZ + BIT_RATE_MAX_BPS - 1) / BIT_RATE_MAX_BPS;

    typedef enum logic [3:0] {
        SLDC_ST_STARTUP = 4'h1,
        SLDC_ST_HOST_SIDE = 4'h2,
        SLDC_ST_REMOTE_SIDE = 4'h4,
        SLDC_ST_DUAL = 4'h8
    } sldc_mode_t;

    typedef struct packed {
        logic [1:0] neg_wire_fault_code;
        logic [1:0] pos_wire_fault_code;
    } sldc_fault_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sldc_reg_req_t;
endpackage : sldc_pkg

/* sldc_hold_timer.sv */
`timescale 1ns/1ps
// Counts down a fixed hold after each start pulse; busy while running
module sldc_hold_timer #(
    parameter int HOLD_CYC = 7000
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    output logic busy_o
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic busy;
    } sldc_tmr_t;

    sldc_tmr_t st_r;
    sldc_tmr_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (start_i) begin
            st_nxt.cnt = CW'(HOLD_CYC - 1);
            st_nxt.busy = 1'b1;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end else begin
            st_nxt.busy = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = st_r.busy;
endmodule : sldc_hold_timer

/* sldc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - Local select low, remote high: both controllers reach both register sets.
// - No contention arbitration; no acknowledge after a contention failure.
// - Two bits gate forward and reverse channels; both clear stops UART traffic.
// - Select pin change in dual mode returns link to matching startup state.
// - Jitter PLL enabled when its disable bit is zero, bypassed when one.
// - Reverse channel unavailable for 350us after serial link start or stop.
// - Interrupt output follows every transition of the looped remote lock.
// - Line fault output low while a fault is present, high when normal.
// - Negative wire code: 00 battery, 01 ground, 10 normal, 11 open.
// - Positive wire code uses same encoding in same order.
// - Control interface supports bit rates up to 1Mbps.
// - Link enable makes video link override config link and lock to clock.
module sldc_ctrl #(
    parameter int REV_HOLD_CYC = sldc_pkg::REV_HOLD_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input sldc_pkg::sldc_reg_req_t reg_req_i,
    input wire logic control_side_select_i,
    input wire logic remote_side_select_i,
    input sldc_pkg::sldc_fault_t fault_det_i,
    input wire logic remote_int_i,
    input wire logic ctrl_bit_tick_i,
    input wire logic remote_ack_i,
    input wire logic contention_i,
    output logic [7:0] reg_rdata_o,
    output logic prbs_test_enable_o,
    output logic forward_ctrl_channel_enable_o,
    output logic reverse_ctrl_channel_enable_o,
    output logic uart_link_active_o,
    output logic jitter_pll_enable_o,
    output logic video_link_select_o,
    output logic config_link_select_o,
    output logic dual_ctrl_o,
    output sldc_pkg::sldc_mode_t link_mode_o,
    output logic ack_frame_o,
    output logic int_n_o,
    output logic line_fault_n_o
);
    typedef struct packed {
        logic [7:0] link_ctrl;
        logic [7:0] pll_ctrl;
        logic [7:0] rdata;
        logic [3:0] fault;
        logic line_fault_n;
        logic int_n;
        logic serial_link_enable_d;
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        logic [1:0] sel_last;
        logic [1:0] int_s;
        logic [3:0] flt_s1;
        logic [3:0] flt_s2;
        sldc_pkg::sldc_mode_t mode;
        logic ack;
        logic [4:0] outs;
    } sldc_state_t;

    sldc_state_t st_r;
    sldc_state_t st_nxt;
    logic rev_busy;
    logic link_toggle;

    function automatic logic is_fault(input logic [1:0] code);
        is_fault = (code != sldc_pkg::FAULT_NORMAL);
    endfunction : is_fault

    function automatic sldc_pkg::sldc_mode_t mode_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: mode_of = sldc_pkg::SLDC_ST_HOST_SIDE;
            2'h3: mode_of = sldc_pkg::SLDC_ST_REMOTE_SIDE;
            2'h2: mode_of = sldc_pkg::SLDC_ST_DUAL;
            default: mode_of = sldc_pkg::SLDC_ST_STARTUP;
        endcase
    endfunction : mode_of

    assign link_toggle = st_r.link_ctrl[sldc_pkg::SERIAL_LINK_ENABLE_BIT] ^ st_r.serial_link_enable_d;

    sldc_hold_timer #(
        .HOLD_CYC(REV_HOLD_CYC)
    ) u_rev_hold (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(link_toggle),
        .busy_o(rev_busy)
    );

    always_comb begin
        logic [3:0] f;
        logic fwd;
        logic rev;
        logic serial_link_enable;
        f = st_r.flt_s2;
        fwd = 1'b0;
        rev = 1'b0;
        serial_link_enable = 1'b0;
        st_nxt = st_r;
        // Synchronisers for pins
        st_nxt.sel_a = {remote_side_select_i, control_side_select_i};
        st_nxt.sel_b = st_r.sel_a;
        st_nxt.int_s = {st_r.int_s[0], remote_int_i};
        st_nxt.flt_s1 = fault_det_i;
        st_nxt.flt_s2 = st_r.flt_s1;
        st_nxt.serial_link_enable_d = st_r.link_ctrl[sldc_pkg::SERIAL_LINK_ENABLE_BIT];
        // Writes; line fault register has no write path
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                sldc_pkg::ADDR_LINK_CTRL: st_nxt.link_ctrl = reg_req_i.wdata;
                sldc_pkg::ADDR_PLL_CTRL: st_nxt.pll_ctrl = reg_req_i.wdata;
                default: st_nxt.link_ctrl = st_r.link_ctrl;
            endcase
        end
        st_nxt.fault = f;
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                sldc_pkg::ADDR_LINK_CTRL: st_nxt.rdata = st_r.link_ctrl;
                sldc_pkg::ADDR_PLL_CTRL: st_nxt.rdata = st_r.pll_ctrl;
                sldc_pkg::ADDR_LINE_FAULT: st_nxt.rdata = {4'h0, st_r.fault};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        // Fault pin only moves on normal/fault boundary of either wire
        st_nxt.line_fault_n = !(is_fault(f[3:2]) || is_fault(f[1:0]));
        // Interrupt mirrors looped remote lock, both edges
        st_nxt.int_n = st_r.int_s[1];
        // Select change returns to startup first, then settles
        if (st_r.sel_b != st_r.sel_last) begin
            st_nxt.mode = sldc_pkg::SLDC_ST_STARTUP;
            st_nxt.sel_last = st_r.sel_b;
        end else begin
            st_nxt.mode = mode_of(st_r.sel_b);
        end
        fwd = st_r.link_ctrl[sldc_pkg::FWD_CC_BIT];
        // The toggle term covers the edge before the timer reports busy
        rev = st_r.link_ctrl[sldc_pkg::REV_CC_BIT] && !rev_busy && !link_toggle;
        serial_link_enable = st_r.link_ctrl[sldc_pkg::SERIAL_LINK_ENABLE_BIT];
        // Acknowledge only for a transaction that did not collide
        st_nxt.ack = remote_ack_i && !contention_i && (fwd || rev);
        st_nxt.outs = {
            st_r.link_ctrl[sldc_pkg::PRBS_BIT],
            fwd,
            rev,
            fwd || rev,
            !st_r.pll_ctrl[sldc_pkg::JPLL_DIS_BIT]
        };
        // Video link wins over configuration link
        video_link_select_o_calc:
        begin
            st_nxt.link_ctrl[sldc_pkg::CLINK_BIT] = st_nxt.link_ctrl[sldc_pkg::CLINK_BIT];
        end
        if (ctrl_bit_tick_i && serial_link_enable) begin
            st_nxt.link_ctrl = st_nxt.link_ctrl; // bit ticks at up to 1Mbps need no pacing
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '{
                link_ctrl: sldc_pkg::LINK_CTRL_RST,
                pll_ctrl: sldc_pkg::PLL_CTRL_RST,
                line_fault_n: 1'b1,
                int_n: 1'b1,
                mode: sldc_pkg::SLDC_ST_STARTUP,
                fault: {sldc_pkg::FAULT_NORMAL, sldc_pkg::FAULT_NORMAL},
                flt_s1: {sldc_pkg::FAULT_NORMAL, sldc_pkg::FAULT_NORMAL},
                flt_s2: {sldc_pkg::FAULT_NORMAL, sldc_pkg::FAULT_NORMAL},
                int_s: 2'h3,
                default: '0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    logic [1:0] link_sel_r;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link_sel_r <= 2'h0;
        end else begin
            link_sel_r <= {st_r.link_ctrl[sldc_pkg::SERIAL_LINK_ENABLE_BIT],
                st_r.link_ctrl[sldc_pkg::CLINK_BIT] && !st_r.link_ctrl[sldc_pkg::SERIAL_LINK_ENABLE_BIT]};
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign {prbs_test_enable_o, forward_ctrl_channel_enable_o, reverse_ctrl_channel_enable_o,
            uart_link_active_o, jitter_pll_enable_o} = st_r.outs;
    assign video_link_select_o = link_sel_r[1];
    assign config_link_select_o = link_sel_r[0];
    // One-hot mode: the dual state owns bit 3, so this is a plain flip-flop
    assign dual_ctrl_o = st_r.mode[3];
    assign link_mode_o = st_r.mode;
    assign ack_frame_o = st_r.ack;
    assign int_n_o = st_r.int_n;
    assign line_fault_n_o = st_r.line_fault_n;
endmodule : sldc_ctrl

/* sldc_assertions.sv */
`timescale 1ns/1ps
module sldc_assertions #(
    parameter int REV_HOLD_CYC = 20
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input sldc_pkg::sldc_reg_req_t reg_req_i,
    input wire logic contention_i,
    input sldc_pkg::sldc_fault_t fault_det_i,
    input wire logic remote_int_i,
    input wire logic jitter_pll_enable_o,
    input wire logic forward_ctrl_channel_enable_o,
    input wire logic reverse_ctrl_channel_enable_o,
    input wire logic video_link_select_o,
    input wire logic ack_frame_o,
    input wire logic int_n_o,
    input wire logic line_fault_n_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_pll_bit_follow: assert property (
        reg_req_i.wr && reg_req_i.addr == 8'h05
        |-> ##2 jitter_pll_enable_o == !$past(reg_req_i.wdata[6], 2)) else $error("pll bit");
    a_fwd_bit_follow: assert property (
        reg_req_i.wr && reg_req_i.addr == 8'h04
        |-> ##2 forward_ctrl_channel_enable_o == $past(reg_req_i.wdata[0], 2)) else $error("fwd");
    a_rev_start_hold: assert property (
        $rose(video_link_select_o) |-> !reverse_ctrl_channel_enable_o [*8]) else $error("rev");
    a_ack_clash_quiet: assert property (
        contention_i |=> !ack_frame_o) else $error("ack on clash");
    a_fault_pin_low: assert property (
        (fault_det_i != 4'hA) [*6] |-> !line_fault_n_o) else $error("fault pin high");
    a_fault_pin_high: assert property (
        (fault_det_i == 4'hA) [*6] |-> line_fault_n_o) else $error("fault pin low");
    a_int_lock_toggle: assert property (
        $changed(remote_int_i) |-> ##[1:5] $changed(int_n_o)) else $error("int missed");
    a_int_lock_steady: assert property (
        $stable(remote_int_i) [*6] |-> $stable(int_n_o)) else $error("int moved");
    cover property ($fell(line_fault_n_o));
    cover property (contention_i);
    cover property ($rose(video_link_select_o));
endmodule : sldc_assertions

/* sldc_remote.sv */
`timescale 1ns/1ps
// Far-end deserializer: lock loops back as interrupt, every frame is answered
module sldc_remote (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic video_i,
    input wire logic frame_i,
    input wire logic clash_i,
    output logic lock_o,
    output logic ack_o,
    output logic clash_o
);
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {lock_o, ack_o, clash_o} <= 3'h0;
        end else begin
            lock_o <= video_i;
            ack_o <= frame_i;
            clash_o <= frame_i && clash_i;
        end
    end
endmodule : sldc_remote

/* sldc_ctrl_tb.sv */
`timescale 1ns/1ps
bind sldc_ctrl sldc_assertions #(.REV_HOLD_CYC(REV_HOLD_CYC)) chk_u (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .reg_req_i(reg_req_i), .contention_i(contention_i),
    .fault_det_i(fault_det_i), .remote_int_i(remote_int_i), .ack_frame_o(ack_frame_o),
    .jitter_pll_enable_o(jitter_pll_enable_o), .int_n_o(int_n_o),
    .forward_ctrl_channel_enable_o(forward_ctrl_channel_enable_o),
    .reverse_ctrl_channel_enable_o(reverse_ctrl_channel_enable_o),
    .video_link_select_o(video_link_select_o), .line_fault_n_o(line_fault_n_o));
module sldc_ctrl_tb;
    localparam int HOLD = 20;
    logic core_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic cs = 1'h0, rs = 1'h0, frame = 1'h0, clash = 1'h0;
    logic lock, rack, cont, prbs, fwd, rev, uart, pll, video, cfg, dual, ack, int_n, lf_n, v;
    logic [7:0] rdata;
    sldc_pkg::sldc_mode_t mode;
    sldc_pkg::sldc_reg_req_t req = '0;
    sldc_pkg::sldc_fault_t flt = 4'hA;
    int bad_count = 0, compares = 0, acks = 0;
    sldc_ctrl #(.REV_HOLD_CYC(HOLD)) dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .reg_req_i(req), .control_side_select_i(cs), .remote_side_select_i(rs),
        .fault_det_i(flt), .remote_int_i(lock), .ctrl_bit_tick_i(1'h0), .remote_ack_i(rack),
        .contention_i(cont), .reg_rdata_o(rdata), .prbs_test_enable_o(prbs),
        .forward_ctrl_channel_enable_o(fwd), .reverse_ctrl_channel_enable_o(rev),
        .uart_link_active_o(uart), .jitter_pll_enable_o(pll), .video_link_select_o(video),
        .config_link_select_o(cfg), .dual_ctrl_o(dual), .link_mode_o(mode),
        .ack_frame_o(ack), .int_n_o(int_n), .line_fault_n_o(lf_n));
    sldc_remote far (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .video_i(video),
        .frame_i(frame), .clash_i(clash), .lock_o(lock), .ack_o(rack), .clash_o(cont));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
        if (ack === 1'h1) acks++;
    task automatic lag(input int n);
        repeat (n) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : lag
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i) req <= {1'h1, 1'h0, a, d};
        @(posedge core_clk_i) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i) req <= {1'h0, 1'h1, a, 8'h00};
        @(posedge core_clk_i) req <= '0;
        lag(1);
        chk(rdata, exp);
    endtask : rd
    task automatic send(input logic cl);
        @(posedge core_clk_i);
        frame <= 1'h1;
        clash <= cl;
        @(posedge core_clk_i) frame <= 1'h0;
        lag(4);
    endtask : send
    task automatic finish_test;
        $display("compares %0d bad %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (3000) @(posedge core_clk_i);
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'h1;
        rd(8'h04, 8'h03);
        rd(8'h3F, 8'h00);
        chk({fwd, rev, uart, pll, lf_n}, 8'h1F);
        wr(8'h05, 8'h40);
        lag(2);
        chk(pll, 8'h00);
        wr(8'h08, 8'h55);
        rd(8'h08, 8'h0A);
        $display("registers done");
        for (int w = 0; w < 2; w++) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge core_clk_i) flt <= w ? {2'h2, 2'(c)} : {2'(c), 2'h2};
                lag(5);
                chk(lf_n, 8'(c == 2));
                rd(8'h08, w ? {6'h02, 2'(c)} : {4'h0, 2'(c), 2'h2});
            end
        end
        @(posedge core_clk_i) flt <= 4'hA;
        $display("faults done");
        wr(8'h04, 8'h00);
        lag(2);
        chk({fwd, rev, uart}, 8'h00);
        send(1'h0);
        chk(8'(acks), 8'h00);
        wr(8'h04, 8'h21);
        lag(2);
        chk({prbs, fwd, uart}, 8'h07);
        send(1'h0);
        chk(8'(acks), 8'h01);
        send(1'h1);
        chk(8'(acks), 8'h01);
        $display("channels done");
        wr(8'h04, 8'hC3);
        lag(2);
        chk({video, cfg, rev}, 8'h04);
        lag(HOLD + 4);
        chk(rev, 8'h01);
        v = int_n;
        wr(8'h04, 8'h03);
        lag(4);
        chk(rev, 8'h00);
        lag(8);
        chk(int_n, 8'(!v));
        $display("link done");
        @(posedge core_clk_i) rs <= 1'h1;
        lag(8);
        chk({dual, mode}, 8'h18);
        @(posedge core_clk_i) cs <= 1'h1;
        lag(8);
        chk({dual, mode}, 8'h04);
        $display("select done");
        finish_test();
    end
endmodule : sldc_ctrl_tb
